// >>> dmc_ctrl.sv
// host controller: apb registers, mode programming, bursts and lock wait
`timescale 1ns/1ps
`include "dmc_params.svh"
module dmc_ctrl #(
    parameter int LOCK_CK = 1024
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    // dram command pins
    output logic ck_out,
    output logic ck_n_out,
    output logic cke_out,
    output logic cs_n_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic [1:0] ba_out,
    output logic bg_out,
    output logic [13:0] a_out,
    output logic odt_out,
    // dram data pins
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe_out,
    output logic dqs_out,
    output logic dqs_oe_out
);
    dmc_pkg::dmc_regs_t q;
    dmc_pkg::dmc_regs_t next_q;
    logic [2:0] rcol;

    ////////////////////////////////////////////////////////////////////////
    dmc_burst_order u_order (
        .start_in(q.addr[2:0]),
        .interleave_in(q.m0[`DMC_M0_BT]),
        .beat_in(q.beat[2:0]),
        .col_out(rcol)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic tick;
        logic fall;
        logic rd_ok;
        logic [31:0] rv;
        logic [3:0] wb;
        logic [2:0] wcol;
        logic [15:0] wr_eff;
        logic [15:0] rtp_eff;
        logic [1:0] bl;
        next_q = q;
        tick = (q.div == 3'(`DMC_HALF_DIV - 1));
        fall = tick & q.ck;
        rd_ok = 1'b1;
        rv = 32'h00000000;
        wb = 4'h0;
        wcol = 3'h0;
        bl = q.m0[`DMC_M0_BL];
        wr_eff = 16'(q.m0[`DMC_M0_WR]);
        if (wr_eff < 16'(`DMC_WR_MIN)) begin
            wr_eff = 16'(`DMC_WR_MIN);
        end
        rtp_eff = 16'(q.m0[`DMC_M0_RTP]);
        if (rtp_eff < 16'(`DMC_RTP_MIN)) begin
            rtp_eff = 16'(`DMC_RTP_MIN);
        end
        // link clock divider and input synchroniser
        next_q.div = tick ? 3'h0 : 3'(q.div + 3'h1);
        if (tick) begin
            next_q.ck = ~q.ck;
            next_q.ckn = q.ck;
        end
        next_q.dq_s1 = dq_in;
        next_q.dq_s2 = q.dq_s1;
        // apb: one wait state, write takes effect on the completing edge
        next_q.pready = 1'b0;
        next_q.pslverr = 1'b0;
        if (paddr_in == `DMC_OFS_CTRL) begin
            rv = {27'h0, q.dll_rst, q.pend, q.op};
        end else if (paddr_in == `DMC_OFS_MODE0) begin
            rv = q.m0;
        end else if (paddr_in == `DMC_OFS_MODE1) begin
            rv = q.m1;
        end else if (paddr_in == `DMC_OFS_ADDR) begin
            rv = q.addr;
        end else if (paddr_in == `DMC_OFS_STAT) begin
            rv = {25'h0, q.dll_rst, q.cke, q.err, q.pend, q.state};
        end else if (paddr_in[7:4] == `DMC_PAGE_WDAT) begin
            rv = {q.wbuf[{paddr_in[3:2], 1'b1}], q.wbuf[{paddr_in[3:2], 1'b0}]};
        end else if (paddr_in[7:4] == `DMC_PAGE_RDAT) begin
            rv = {q.rbuf[{paddr_in[3:2], 1'b1}], q.rbuf[{paddr_in[3:2], 1'b0}]};
        end else begin
            rd_ok = 1'b0;
        end
        if (psel_in && penable_in && !q.pready) begin
            next_q.pready = 1'b1;
            next_q.prdata = pwrite_in ? 32'h00000000 : rv;
            next_q.pslverr = ~rd_ok;
        end
        if (psel_in && penable_in && q.pready && pwrite_in) begin
            if (paddr_in == `DMC_OFS_CTRL) begin
                if (pwdata_in[`DMC_C_GO] && !q.pend) begin
                    next_q.pend = 1'b1;
                    next_q.op = dmc_pkg::dmc_op_t'(pwdata_in[`DMC_C_OP]);
                    next_q.dll_rst = pwdata_in[`DMC_C_DLLRST];
                end else if (pwdata_in[`DMC_C_GO]) begin
                    next_q.err = 1'b1;
                end
            end else if (paddr_in == `DMC_OFS_MODE0) begin
                next_q.m0 = pwdata_in;
            end else if (paddr_in == `DMC_OFS_MODE1) begin
                next_q.m1 = pwdata_in;
            end else if (paddr_in == `DMC_OFS_ADDR) begin
                next_q.addr = pwdata_in;
            end else if (paddr_in == `DMC_OFS_STAT) begin
                if (pwdata_in[`DMC_ST_ERR]) begin
                    next_q.err = 1'b0;
                end
            end else if (paddr_in[7:4] == `DMC_PAGE_WDAT) begin
                next_q.wbuf[{paddr_in[3:2], 1'b0}] = pwdata_in[15:0];
                next_q.wbuf[{paddr_in[3:2], 1'b1}] = pwdata_in[31:16];
            end
        end
        // command sequencer, paced by link clock ticks
        case (q.state)
            dmc_pkg::ST_IDLE: begin
                if (q.pend && fall) begin
                    next_q.pend = 1'b0;
                    next_q.beat = 4'h0;
                    next_q.fchop = (bl == `DMC_BL_BC4);
                    next_q.chop = (bl == `DMC_BL_BC4) ||
                        ((bl == `DMC_BL_OTF) && q.addr[`DMC_AD_CHOP]);
                    next_q.nbeat = next_q.chop ? `DMC_BEATS_4 : `DMC_BEATS_8;
                    next_q.a = 14'h0000;
                    next_q.ba = 2'h0;
                    next_q.bg = 1'b0;
                    next_q.state = dmc_pkg::ST_CMD;
                    case (q.op)
                        dmc_pkg::OP_MRS0: begin
                            next_q.cmd = `DMC_CMD_MRS;
                            next_q.a[`DMC_A_BL] = bl;
                            next_q.a[`DMC_A_BT] = q.m0[`DMC_M0_BT];
                            next_q.a[`DMC_A_DLLRST] = q.dll_rst;
                            next_q.a[`DMC_A_WR] = q.m0[`DMC_M0_WRCODE];
                            next_q.a[`DMC_A_CL] = q.m0[14:12];
                            next_q.a[`DMC_A_CL0] = q.m0[11];
                            next_q.dll_rst = 1'b0;
                        end
                        dmc_pkg::OP_MRS1: begin
                            next_q.cmd = `DMC_CMD_MRS;
                            next_q.ba = 2'h1;
                            next_q.a[`DMC_A_DLLEN] = q.m1[`DMC_M1_DLLEN];
                            next_q.a[`DMC_A_AL] = 2'h0;
                            if (q.m1[`DMC_M1_DLLEN]) begin
                                next_q.a[`DMC_A_RTTNOM] = q.m1[`DMC_M1_RTTNOM];
                            end
                        end
                        dmc_pkg::OP_MRS2: begin
                            next_q.cmd = `DMC_CMD_MRS;
                            next_q.ba = 2'h2;
                            next_q.a[`DMC_A_CWL] = q.m1[`DMC_M1_CWLCODE];
                            next_q.a[`DMC_A_CRC] = q.m1[`DMC_M1_CRC];
                            if (q.m1[`DMC_M1_DLLEN]) begin
                                next_q.a[`DMC_A_RTTWR] = q.m1[`DMC_M1_RTTWR];
                            end
                        end
                        dmc_pkg::OP_ACT: begin
                            next_q.cmd = `DMC_CMD_ACT;
                            next_q.ba = q.addr[`DMC_AD_BA];
                            next_q.bg = q.addr[`DMC_AD_BG];
                            next_q.a = q.addr[`DMC_AD_ROW];
                        end
                        dmc_pkg::OP_RD, dmc_pkg::OP_WR: begin
                            next_q.cmd = (q.op == dmc_pkg::OP_RD) ? `DMC_CMD_RD : `DMC_CMD_WR;
                            next_q.ba = q.addr[`DMC_AD_BA];
                            next_q.bg = q.addr[`DMC_AD_BG];
                            next_q.a[9:0] = q.addr[`DMC_AD_COL];
                            // the chop select pin is active low
                            next_q.a[`DMC_A_CHOP] = ~q.addr[`DMC_AD_CHOP];
                            if (bl == `DMC_BL_RSV) begin
                                next_q.cmd = `DMC_CMD_DES;
                                next_q.err = 1'b1;
                                next_q.state = dmc_pkg::ST_IDLE;
                            end
                        end
                        dmc_pkg::OP_SRE: begin
                            next_q.cmd = `DMC_CMD_SRE;
                            next_q.cke = 1'b0;
                        end
                        default: begin
                            next_q.cmd = `DMC_CMD_DES;
                            next_q.cke = 1'b1;
                        end
                    endcase
                end
            end
            dmc_pkg::ST_CMD: begin
                if (fall) begin
                    next_q.cmd = `DMC_CMD_DES;
                    next_q.state = dmc_pkg::ST_REC;
                    next_q.cnt = `DMC_TMOD_CK;
                    case (q.op)
                        dmc_pkg::OP_RD: begin
                            next_q.state = dmc_pkg::ST_LAT;
                            next_q.cnt = 16'(q.m0[`DMC_M0_CL]);
                        end
                        dmc_pkg::OP_WR: begin
                            next_q.state = dmc_pkg::ST_LAT;
                            next_q.cnt = 16'(q.m1[`DMC_M1_CWL]);
                        end
                        dmc_pkg::OP_ACT: begin
                            next_q.cnt = `DMC_TRCD_CK;
                        end
                        dmc_pkg::OP_SRE: begin
                            next_q.state = dmc_pkg::ST_IDLE;
                        end
                        dmc_pkg::OP_SRX: begin
                            next_q.state = dmc_pkg::ST_LOCK;
                            next_q.cnt = 16'(LOCK_CK);
                        end
                        default: begin
                            if (q.a[`DMC_A_DLLRST] && q.op == dmc_pkg::OP_MRS0) begin
                                next_q.state = dmc_pkg::ST_LOCK;
                                next_q.cnt = 16'(LOCK_CK);
                            end
                        end
                    endcase
                end
            end
            dmc_pkg::ST_LAT: begin
                if (fall) begin
                    if (q.cnt <= 16'h0001) begin
                        next_q.state = dmc_pkg::ST_BURST;
                        if (q.op == dmc_pkg::OP_WR) begin
                            wcol = q.chop ? {q.addr[2], 2'h0} : 3'h0;
                            next_q.dq = q.wbuf[wcol];
                            next_q.dq_oe = 1'b1;
                            next_q.dqs_oe = 1'b1;
                            next_q.dqs = 1'b1;
                        end
                    end else begin
                        next_q.cnt = 16'(q.cnt - 16'h0001);
                    end
                end
            end
            dmc_pkg::ST_BURST: begin
                if (tick) begin
                    wb = 4'(q.beat + 4'h1);
                    next_q.beat = wb;
                    if (q.op == dmc_pkg::OP_RD) begin
                        next_q.rbuf[rcol] = q.dq_s2;
                    end else begin
                        wcol = q.chop ? {q.addr[2], wb[1:0]} : wb[2:0];
                        next_q.dq = q.wbuf[wcol];
                        next_q.dqs = ~q.dqs;
                    end
                    if (wb == q.nbeat) begin
                        next_q.state = dmc_pkg::ST_REC;
                        next_q.dq_oe = 1'b0;
                        next_q.dqs_oe = 1'b0;
                        next_q.dqs = 1'b0;
                        next_q.cnt = rtp_eff;
                        if (q.op == dmc_pkg::OP_WR) begin
                            next_q.cnt = wr_eff;
                            if (q.fchop) begin
                                next_q.cnt = (wr_eff > `DMC_CHOP_PULL) ?
                                    16'(wr_eff - `DMC_CHOP_PULL) : 16'h0001;
                            end
                        end
                    end
                end
            end
            default: begin
                if (fall) begin
                    if (q.cnt <= 16'h0001) begin
                        next_q.state = dmc_pkg::ST_IDLE;
                    end else begin
                        next_q.cnt = 16'(q.cnt - 16'h0001);
                    end
                end
            end
        endcase
        if (next_q.state == dmc_pkg::ST_LOCK) begin
            next_q.cke = 1'b1;
        end
        next_q.termination_pin = q.m1[`DMC_M1_ODT] && q.m1[`DMC_M1_DLLEN] &&
            (next_q.state != dmc_pkg::ST_LOCK) && (q.state != dmc_pkg::ST_LOCK);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= '0;
            q.m1 <= `DMC_M1_RST;
            q.cke <= 1'b1;
            q.ckn <= 1'b1;
            q.cmd <= `DMC_CMD_DES;
        end else begin
            q <= next_q;
        end
    end

    assign pready_out = q.pready;
    assign prdata_out = q.prdata;
    assign pslverr_out = q.pslverr;
    assign ck_out = q.ck;
    assign ck_n_out = q.ckn;
    assign cke_out = q.cke;
    assign {cs_n_out, ras_n_out, cas_n_out, we_n_out} = q.cmd;
    assign ba_out = q.ba;
    assign bg_out = q.bg;
    assign a_out = q.a;
    assign odt_out = q.termination_pin;
    assign dq_out = q.dq;
    assign dq_oe_out = q.dq_oe;
    assign dqs_out = q.dqs;
    assign dqs_oe_out = q.dqs_oe;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);

    property p_lock_cke;
        q.state == dmc_pkg::ST_LOCK |-> q.cke;
    endproperty
    a_lock_cke: assert property (p_lock_cke) else $error("cke low during lock");

    property p_lock_hold;
        $rose(q.state == dmc_pkg::ST_LOCK) |-> (q.state == dmc_pkg::ST_LOCK && q.cmd != `DMC_CMD_RD)[*8];
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock wait cut short");

    property p_lock_odt;
        q.state == dmc_pkg::ST_LOCK |-> !q.termination_pin;
    endproperty
    a_lock_odt: assert property (p_lock_odt) else $error("odt high during lock");

    property p_dlloff_odt;
        $past(!q.m1[`DMC_M1_DLLEN]) |-> !q.termination_pin;
    endproperty
    a_dlloff_odt: assert property (p_dlloff_odt) else $error("odt high with loop off");

    property p_mrs1_nom;
        $rose(q.cmd == `DMC_CMD_MRS) && q.ba == 2'h1 && $past(!q.m1[`DMC_M1_DLLEN])
            |-> q.a[`DMC_A_RTTNOM] == 3'h0;
    endproperty
    a_mrs1_nom: assert property (p_mrs1_nom) else $error("nominal termination on, loop off");

    property p_mrs1_al;
        q.cmd == `DMC_CMD_MRS && q.ba == 2'h1 |-> q.a[`DMC_A_AL] == 2'h0;
    endproperty
    a_mrs1_al: assert property (p_mrs1_al) else $error("additive latency nonzero");

    property p_mrs2_wr;
        $rose(q.cmd == `DMC_CMD_MRS) && q.ba == 2'h2 && $past(!q.m1[`DMC_M1_DLLEN])
            |-> q.a[`DMC_A_RTTWR] == 3'h0;
    endproperty
    a_mrs2_wr: assert property (p_mrs2_wr) else $error("write termination on, loop off");

    property p_bl_rsv;
        $rose(q.cmd == `DMC_CMD_RD || q.cmd == `DMC_CMD_WR)
            |-> $past(q.m0[`DMC_M0_BL]) != `DMC_BL_RSV;
    endproperty
    a_bl_rsv: assert property (p_bl_rsv) else $error("burst with reserved length");

    property p_wr_rec;
        $rose(q.state == dmc_pkg::ST_REC) && q.op == dmc_pkg::OP_WR
            |-> q.cnt + (q.fchop ? `DMC_CHOP_PULL : 16'h0000) >= 16'(`DMC_WR_MIN);
    endproperty
    a_wr_rec: assert property (p_wr_rec) else $error("write recovery too short");

    property p_rd_rtp;
        $rose(q.state == dmc_pkg::ST_REC) && q.op == dmc_pkg::OP_RD
            |-> q.cnt >= 16'(`DMC_RTP_MIN);
    endproperty
    a_rd_rtp: assert property (p_rd_rtp) else $error("read to precharge too short");

    c_lock: cover property ($fell(q.state == dmc_pkg::ST_LOCK));
    c_read: cover property (q.state == dmc_pkg::ST_BURST && q.op == dmc_pkg::OP_RD);
    c_chop_wr: cover property (q.state == dmc_pkg::ST_BURST && q.op == dmc_pkg::OP_WR && q.chop);
endmodule // dmc_ctrl

// >>> dmc_params.svh
// constants of the dram mode, burst and latency controller
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH
// Overview of operation
// - wait loop lock time before reads, termination
// - keep clock enable high during lock
// - burst type bit: sequential or interleaved
// - length field picks chop, eight or fly
// - length codes: eight, fly, chop, reserved
// - fixed chop pulls write timing two clocks
// - write recovery at least rounded-up minimum
// - read-to-precharge at least rounded-up minimum
// - loop off: nominal termination forced off
// - loop off: write termination cleared
// - additive latency zero on sixteen-bit part

// apb register offsets
`define DMC_OFS_CTRL 8'h00
`define DMC_OFS_MODE0 8'h04
`define DMC_OFS_MODE1 8'h08
`define DMC_OFS_ADDR 8'h0C
`define DMC_OFS_STAT 8'h10
`define DMC_PAGE_WDAT 4'h2
`define DMC_PAGE_RDAT 4'h3
// control register fields
`define DMC_C_OP 2:0
`define DMC_C_GO 3
`define DMC_C_DLLRST 4
// mode0 register fields
`define DMC_M0_BL 1:0
`define DMC_M0_BT 2
`define DMC_M0_WRCODE 5:3
`define DMC_M0_CL 10:6
`define DMC_M0_CLCODE 14:11
`define DMC_M0_WR 19:15
`define DMC_M0_RTP 24:20
// mode1 register fields
`define DMC_M1_DLLEN 0
`define DMC_M1_RTTNOM 3:1
`define DMC_M1_AL 5:4
`define DMC_M1_RTTWR 8:6
`define DMC_M1_CRC 9
`define DMC_M1_CWLCODE 12:10
`define DMC_M1_CWL 17:13
`define DMC_M1_ODT 18
`define DMC_M1_RST 32'h00000001
// address register fields
`define DMC_AD_COL 9:0
`define DMC_AD_CHOP 11
`define DMC_AD_BA 13:12
`define DMC_AD_BG 14
`define DMC_AD_ROW 31:18
// status register fields
`define DMC_ST_ERR 4
// mode register bits on the address pins
`define DMC_A_BL 1:0
`define DMC_A_CL0 2
`define DMC_A_BT 3
`define DMC_A_CL 6:4
`define DMC_A_DLLRST 8
`define DMC_A_WR 11:9
`define DMC_A_DLLEN 0
`define DMC_A_AL 4:3
`define DMC_A_RTTNOM 10:8
`define DMC_A_CWL 5:3
`define DMC_A_RTTWR 11:9
`define DMC_A_CRC 12
`define DMC_A_CHOP 12
// {cs_n, ras_n, cas_n, we_n}
`define DMC_CMD_MRS 4'h0
`define DMC_CMD_SRE 4'h1
`define DMC_CMD_ACT 4'h3
`define DMC_CMD_WR 4'h4
`define DMC_CMD_RD 4'h5
`define DMC_CMD_DES 4'hF
// burst length codes
`define DMC_BL_8 2'h0
`define DMC_BL_OTF 2'h1
`define DMC_BL_BC4 2'h2
`define DMC_BL_RSV 2'h3
`define DMC_BEATS_8 4'h8
`define DMC_BEATS_4 4'h4
`define DMC_CHOP_PULL 16'h0002
// timing
`define DMC_CORE_NS 8
`define DMC_HALF_DIV 4
`define DMC_TCK_NS (2 * `DMC_HALF_DIV * `DMC_CORE_NS)
`define DMC_TWR_NS 15
`define DMC_READ_TO_PRECHARGE_TIME_NS 8
`define DMC_WR_MIN ((`DMC_TWR_NS + `DMC_TCK_NS - 1) / `DMC_TCK_NS)
`define DMC_RTP_MIN ((`DMC_READ_TO_PRECHARGE_TIME_NS + `DMC_TCK_NS - 1) / `DMC_TCK_NS)
`define DMC_TMOD_CK 16'h0018
`define DMC_TRCD_CK 16'h0004
`endif

// >>> dmc_pkg.sv
// types of the dram mode, burst and latency controller
package dmc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_LAT = 3'b010,
        ST_BURST = 3'b011,
        ST_REC = 3'b100,
        ST_LOCK = 3'b101
    } dmc_state_t;
    typedef enum logic [2:0] {
        OP_MRS0 = 3'b000,
        OP_MRS1 = 3'b001,
        OP_MRS2 = 3'b010,
        OP_ACT = 3'b011,
        OP_RD = 3'b100,
        OP_WR = 3'b101,
        OP_SRE = 3'b110,
        OP_SRX = 3'b111
    } dmc_op_t;
    typedef struct packed {
        dmc_state_t state;
        dmc_op_t op;
        logic pend;
        logic dll_rst;
        logic err;
        logic chop;
        logic fchop;
        logic [31:0] m0;
        logic [31:0] m1;
        logic [31:0] addr;
        logic [7:0][15:0] wbuf;
        logic [7:0][15:0] rbuf;
        logic [2:0] div;
        logic [15:0] cnt;
        logic [3:0] beat;
        logic [3:0] nbeat;
        logic [15:0] dq_s1;
        logic [15:0] dq_s2;
        logic ck;
        logic ckn;
        logic cke;
        logic [3:0] cmd;
        logic [1:0] ba;
        logic bg;
        logic [13:0] a;
        logic termination_pin;
        logic [15:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_oe;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } dmc_regs_t;
endpackage

// >>> dmc_burst_order.sv
// column index of a read beat for sequential or interleaved bursts
`timescale 1ns/1ps
module dmc_burst_order (
    // burst start and beat
    input wire logic [2:0] start_in,
    input wire logic interleave_in,
    input wire logic [2:0] beat_in,
    // column of this beat
    output logic [2:0] col_out
);
    always_comb begin
        if (interleave_in) begin
            col_out = start_in ^ beat_in;
        end else begin
            col_out = {start_in[2] ^ beat_in[2], 2'(start_in[1:0] + beat_in[1:0])};
        end
    end
endmodule // dmc_burst_order

// >>> dmc_dev_model.sv
// behavioural memory device answering the controller's command and data pins
`timescale 1ns/1ps
module dmc_dev_model #(
    parameter int LAT = 5
) (
    // clock and command pins
    input wire logic core_clk_in,
    input wire logic ck_in,
    input wire logic [3:0] cmd_in,
    input wire logic [1:0] ba_in,
    input wire logic [13:0] a_in,
    // write data from the controller
    input wire logic [15:0] dq_in,
    input wire logic dq_oe_in,
    input wire logic dqs_in,
    // read data and captured write beats
    output logic [15:0] dq_out,
    output logic [7:0][15:0] wmem_out = '0
);
    logic ck_q = 1'b0, dqs_q = 1'b0, oe_q = 1'b0, inter = 1'b0, chop = 1'b0, busy = 1'b0;
    logic [1:0] len = 2'h0;
    logic [2:0] st = 3'h0, wi = 3'h0, col;
    logic [7:0] t = 8'h00;
    int b;
    always @(posedge core_clk_in) begin
        ck_q <= ck_in;
        dqs_q <= dqs_in;
        oe_q <= dq_oe_in;
        t <= t + 8'h01;
        // only burst length and type are kept from mode register 0; the reset bit is ignored
        if (ck_in && !ck_q && cmd_in == 4'h0 && ba_in == 2'h0) begin
            len <= a_in[1:0];
            inter <= a_in[3];
        end
        if (ck_in && !ck_q && cmd_in == 4'h5) begin
            busy <= 1'b1;
            t <= 8'h00;
            st <= a_in[2:0];
            chop <= len == 2'h2 || (len == 2'h1 && !a_in[12]);
        end
        if (busy && int'(t) > 8 * LAT + 40) busy <= 1'b0;
        if (dq_oe_in && !oe_q) wmem_out[0] <= dq_in;
        wi <= (dq_oe_in && !oe_q) ? 3'h1 : wi;
        if (dq_oe_in && oe_q && dqs_in != dqs_q) begin
            wmem_out[wi] <= dq_in;
            wi <= wi + 3'h1;
        end
    end
    // each beat stands four cycles around the controller's synchronised sample
    always_comb begin
        b = int'(t) - (8 * LAT + 2);
        col = inter ? st ^ 3'(b / 4) : {st[2] ^ b[4], st[1:0] + b[3:2]};
        if (busy && b >= 0 && b < 32 && !(chop && b >= 16)) dq_out = 16'hA000 | 16'(col);
        else dq_out = {8'hC3, t};
    end
endmodule // dmc_dev_model

// >>> dram_mode_burst_latency_config_bench.sv
// self-checking bench for the dram mode, burst and latency controller
`timescale 1ns/1ps
`include "dmc_params.svh"
module dram_mode_burst_latency_config_bench;
    logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, bg, termination_pin, dq_oe, dqs, dqs_oe;
    logic [1:0] ba;
    logic [13:0] a;
    logic [15:0] dq_w, dq_r;
    logic [7:0][15:0] wmem;
    logic [6:0] rc [5] = '{7'h0D, 7'h27, 7'h16, 7'h31, 7'h4D};
    int n_fail = 0, total_checks = 0;
    dmc_ctrl #(.LOCK_CK(4)) u_dmc_ctrl (.core_clk_in(core_clk), .resetn_in(resetn),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
        .ck_out(ck), .ck_n_out(ck_n), .cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n),
        .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba), .bg_out(bg), .a_out(a), .odt_out(termination_pin),
        .dq_in(dq_r), .dq_out(dq_w), .dq_oe_out(dq_oe), .dqs_out(dqs), .dqs_oe_out(dqs_oe));
    dmc_dev_model #(.LAT(5)) u_dmc_dev_model (.core_clk_in(core_clk), .ck_in(ck),
        .cmd_in({cs_n, ras_n, cas_n, we_n}), .ba_in(ba), .a_in(a), .dq_in(dq_w),
        .dq_oe_in(dq_oe), .dqs_in(dqs), .dq_out(dq_r), .wmem_out(wmem));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // values read right after an edge are those sampled at that edge
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) n_fail++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run(input logic [31:0] c);
        int k;
        k = 0;
        apb(1'b1, `DMC_OFS_CTRL, c | 32'h8);
        do begin
            apb(1'b0, `DMC_OFS_STAT, 32'h0);
            k++;
        end while (rd[3:0] !== 4'h0 && k < 400);
        if (rd[3:0] !== 4'h0) n_fail++;
    endtask
    task automatic setup(input logic [31:0] m0, input logic [11:0] col);
        apb(1'b1, `DMC_OFS_MODE0, m0 | 32'h140);
        run(32'h0);
        apb(1'b1, `DMC_OFS_ADDR, {20'h0, col});
    endtask
    initial begin
        #600000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        apb(1'b0, `DMC_OFS_MODE1, 32'h0);
        chk("mode1 reset value", 32'h1, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        run(32'h10);
        apb(1'b0, `DMC_OFS_CTRL, 32'h0);
        chk("loop reset bit", 32'h0, {31'h0, rd[4]});
        run(32'h3);
        for (int n = 0; n < 5; n++) begin
            setup({29'h0, rc[n][5], rc[n][4:3]}, {rc[n][6], 8'h0, rc[n][2:0]});
            run(32'h4);
            for (int k = 0; k < 4; k++) begin
                apb(1'b0, 8'h30 + 8'(4 * k), 32'h0);
                if ((rc[n][4:3] != 2'h2 && !rc[n][6]) || k / 2 == rc[n][2])
                    chk("read pair", {16'hA000 | 16'(2 * k + 1), 16'hA000 | 16'(2 * k)}, rd);
            end
        end
        apb(1'b1, `DMC_OFS_MODE1, 32'h403CE);
        run(32'h1);
        run(32'h2);
        chk("odt with loop off", 32'h0, {31'h0, termination_pin});
        for (int k = 0; k < 4; k++)
            apb(1'b1, 8'h20 + 8'(4 * k), {16'hB000 | 16'(2 * k + 1), 16'hB000 | 16'(2 * k)});
        setup(32'h4, 12'h005);
        run(32'h5);
        for (int k = 0; k < 8; k++)
            chk("written beat", 32'hB000 | 32'(k), {16'h0, wmem[k]});
        setup(32'h2, 12'h006);
        run(32'h5);
        for (int k = 0; k < 4; k++)
            chk("chopped beat", 32'hB004 | 32'(k), {16'h0, wmem[k]});
        apb(1'b1, `DMC_OFS_MODE1, 32'h40001);
        apb(1'b1, `DMC_OFS_MODE0, 32'h143);
        run(32'h4);
        apb(1'b0, `DMC_OFS_STAT, 32'h0);
        chk("reserved length error", 32'h1, {31'h0, rd[4]});
        chk("odt with loop on", 32'h1, {31'h0, termination_pin});
        apb(1'b1, `DMC_OFS_STAT, 32'h10);
        apb(1'b0, `DMC_OFS_STAT, 32'h0);
        chk("error cleared", 32'h0, {31'h0, rd[4]});
        run(32'h6);
        chk("cke in self refresh", 32'h0, {31'h0, rd[5]});
        run(32'h7);
        chk("cke after self refresh", 32'h1, {31'h0, rd[5]});
        final_report();
    end
endmodule // dram_mode_burst_latency_config_bench
